/* verilog/sc_seq_pkg.sv */
// Shared constants and types of the smart card session sequencer.
// Assumes a single system clock; all pins are synchronised inside the top module.
package sc_seq_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register map (word aligned, AHB-Lite byte addresses)
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'h87;
	localparam logic [7:0] STAT_EVT_MASK = 8'h7E;

	// Control bit positions
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_WARM_BIT = 1;
	localparam int CTRL_VSEL_BIT = 2;
	localparam int CTRL_IOEN_BIT = 7;

	// Status bit positions
	localparam int STAT_PRESENT_BIT = 0;
	localparam int STAT_EARLY_BIT = 1;
	localparam int STAT_MUTE_BIT = 2;
	localparam int STAT_OVERCUR_BIT = 3;
	localparam int STAT_OVERTEMP_BIT = 4;
	localparam int STAT_VCCF_BIT = 5;
	localparam int STAT_PRESCHG_BIT = 6;

	////////////////////////////////////////////////////////////////////////////
	// Timing defaults, in device clock cycles unless named otherwise
	localparam int T1_DEFAULT = 256;
	localparam int T2_DEFAULT = 256;
	localparam int T3_DEFAULT = 256;
	localparam int T4_DEFAULT = 256;
	localparam int WARM_CARD_CYCLES = 42000;
	localparam int MUTE_CARD_CYCLES = 40000;

	////////////////////////////////////////////////////////////////////////////
	// Index of each synchronised pin
	localparam int PIN_HOST = 0;
	localparam int PIN_CARD = 3;
	localparam int PIN_CLK = 6;
	localparam int PIN_PRES = 7;
	localparam int PIN_VCCOK = 8;
	localparam int PIN_VDDOK = 9;
	localparam int PIN_OC = 10;
	localparam int PIN_OT = 11;
	localparam int NPINS = 12;

	// Register selection result
	localparam logic [1:0] SEL_NONE = 2'h0;
	localparam logic [1:0] SEL_CTRL = 2'h1;
	localparam logic [1:0] SEL_STATUS = 2'h2;

	// Sequencer states
	typedef enum logic [3:0] {
		SEQ_OFF = 4'h0,
		SEQ_ACT1 = 4'h1,
		SEQ_ACT2 = 4'h2,
		SEQ_ACT3 = 4'h3,
		SEQ_ON = 4'h4,
		SEQ_DEA1 = 4'h5,
		SEQ_DEA2 = 4'h6,
		SEQ_DEA3 = 4'h7,
		SEQ_DEA4 = 4'h8
	} seq_t;

	// Data line direction per lane
	typedef enum logic [1:0] {
		DIR_IDLE = 2'h0,
		DIR_H2C = 2'h1,
		DIR_C2H = 2'h2
	} dir_t;

endpackage : sc_seq_pkg

/* verilog/steer_if.sv */
// Link between the sequencer top and the I/O direction steering module.
// Levels are already synchronised to i_clk_sys; lane 0 data, 1 aux a, 2 aux b.
interface steer_if;
	logic en;
	logic [2:0] host_in;
	logic [2:0] card_in;
	logic [2:0] host_pull;
	logic [2:0] card_pull;

	modport ctrl (output en, output host_in, output card_in, input host_pull, input card_pull);
	modport steer (input en, input host_in, input card_in, output host_pull, output card_pull);
endinterface : steer_if

/* verilog/io_dir_steer.sv */
// Direction steering of the three host/card line pairs.
// Assumes synchronised inputs and an enable that is high only during reception.
module io_dir_steer
	import sc_seq_pkg::*;
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	// Steering link
	steer_if.steer bus
);

	typedef struct packed {
		dir_t [2:0] dir;
		logic [2:0] host_prev;
		logic [2:0] card_prev;
		logic [2:0] host_pull;
		logic [2:0] card_pull;
	} steer_state_t;

	steer_state_t q;
	steer_state_t d;

	////////////////////////////////////////////////////////////////////////////
	// First falling edge picks the input line, its rising edge frees both
	always_comb begin
		d = q;
		for (int i = 0; i < 3; i++) begin
			d.host_prev[i] = bus.host_in[i];
			d.card_prev[i] = bus.card_in[i];
			case (q.dir[i])
				DIR_IDLE: begin
					if (!bus.en) begin
						d.dir[i] = DIR_IDLE;
					end else if (q.host_prev[i] && !bus.host_in[i]) begin
						d.dir[i] = DIR_H2C;
					end else if (q.card_prev[i] && !bus.card_in[i]) begin
						d.dir[i] = DIR_C2H;
					end
				end
				DIR_H2C: begin
					if (!bus.en || (!q.host_prev[i] && bus.host_in[i])) begin
						d.dir[i] = DIR_IDLE;
					end
				end
				DIR_C2H: begin
					if (!bus.en || (!q.card_prev[i] && bus.card_in[i])) begin
						d.dir[i] = DIR_IDLE;
					end
				end
				default: begin
					d.dir[i] = DIR_IDLE;
				end
			endcase
			// Output line copies the low level of the input line
			d.card_pull[i] = (d.dir[i] == DIR_H2C) && !bus.host_in[i];
			d.host_pull[i] = (d.dir[i] == DIR_C2H) && !bus.card_in[i];
		end
	end

	// State register
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Results to the top
	assign bus.host_pull = q.host_pull;
	assign bus.card_pull = q.card_pull;

	// The opposite line never copies while the lane is idle
	idle_no_drive_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(q.dir[0] == DIR_IDLE) |-> !q.card_pull[0] && !q.host_pull[0])
		else $error("idle lane drives a line");

endmodule : io_dir_steer

/* verilog/sc_session_seq.sv */
// Smart card session sequencer: activation, deactivation, warm reset, interrupt,
// AHB-Lite control/status registers. Assumes pins are asynchronous to i_clk_sys
// and that each card/host line has an external pull-up.
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Interrupt stays low after reset until digital supply has been stable.
// - Writing one to control bit 0 starts the activation sequence.
// - Card supply not valid at end of first interval aborts the session.
// - Reception after interval one, clock after two, reset high after three.
// - Clearing start or any fault or card removal begins deactivation.
// - Reset low, clock low, data low, then supply off, one interval each.
// - Interrupt output is active low and asserted on supply faults.
// - Interrupt also asserts on early or mute answer, card change, protection.
// - Reading the status register releases the status-caused interrupt.
// - Power-on reset returns control and status registers to defaults.
// - Digital supply fault keeps registers, holds interrupt for one interval.
// - Control bit 1 sends a warm reset of 42,000 card clock cycles.
// - Warm reset bit clears itself on card answer or mute.
// - Card lines low after reset, released high when reception starts.
// - Host lines are high after reset.
// - With control bit 7 set, first falling line becomes the input.
// - Rising edge of the input line returns both lines to idle.
// - Control bit 2 selects the 5 V or 3 V card supply level.
// - Over-temperature sets status bit 4, interrupts, and deactivates.
// - Only transitions of the start bit act; early settings are ignored.
//
// Chosen here: the AHB-Lite register port and the address map.
module sc_session_seq
	import sc_seq_pkg::*;
#(
	parameter int T1_CYCLES = T1_DEFAULT,
	parameter int T2_CYCLES = T2_DEFAULT,
	parameter int T3_CYCLES = T3_DEFAULT,
	parameter int T4_CYCLES = T4_DEFAULT,
	parameter int WARM_CYCLES = WARM_CARD_CYCLES,
	parameter int MUTE_CYCLES = MUTE_CARD_CYCLES
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// Interrupt
	output logic o_int_n,
	// Supervisors and card detect
	input wire logic i_card_present,
	input wire logic i_vcc_ok,
	input wire logic i_vdd_ok,
	input wire logic i_overcurrent,
	input wire logic i_overtemp,
	// Card supply and clock
	input wire logic i_card_clk_src,
	output logic o_vcc_en,
	output logic o_vcc_5v_sel,
	output logic o_card_clk,
	output logic o_card_rst,
	// Card side lines
	input wire logic i_card_data_line,
	output logic o_card_data_line,
	output logic o_card_data_line_oe,
	input wire logic i_card_aux_line_a,
	output logic o_card_aux_line_a,
	output logic o_card_aux_line_a_oe,
	input wire logic i_card_aux_line_b,
	output logic o_card_aux_line_b,
	output logic o_card_aux_line_b_oe,
	// Host side lines
	input wire logic i_host_side_data_line,
	output logic o_host_side_data_line,
	output logic o_host_side_data_line_oe,
	input wire logic i_host_side_aux_a,
	output logic o_host_side_aux_a,
	output logic o_host_side_aux_a_oe,
	input wire logic i_host_side_aux_b,
	output logic o_host_side_aux_b,
	output logic o_host_side_aux_b_oe
);

	typedef struct packed {
		logic [NPINS-1:0] sync1;
		logic [NPINS-1:0] sync2;
		logic clk_prev;
		logic pres_prev;
		logic data_prev;
		logic [23:0] vdd_cnt;
		logic vdd_stable;
		logic [7:0] ctrl;
		logic [7:0] status;
		logic start_prev;
		logic warm_prev;
		seq_t state;
		logic [23:0] cnt;
		logic warm_active;
		logic atr_wait;
		logic [23:0] atr_cnt;
		logic ph_write;
		logic [1:0] ph_sel;
		logic [31:0] hrdata;
		logic hready;
		logic vcc_en;
		logic vsel;
		logic clk_en;
		logic rst;
		logic recv;
		logic card_clk;
		logic int_n;
		logic [2:0] card_oe;
		logic [2:0] host_oe;
		logic line_val;
	} seq_state_t;

	seq_state_t q;
	seq_state_t d;
	steer_if st ();

	logic [NPINS-1:0] pins;
	logic [7:0] evt;
	logic card_edge;
	logic data_fall;
	logic start_rise;
	logic start_fall;
	logic fault;
	logic acc;
	logic rd_status;

	// Register select from a byte address
	function automatic logic [1:0] reg_sel(input logic [31:0] addr);
		if (addr == {24'h000000, CTRL_OFFSET}) begin
			reg_sel = SEL_CTRL;
		end else if (addr == {24'h000000, STATUS_OFFSET}) begin
			reg_sel = SEL_STATUS;
		end else begin
			reg_sel = SEL_NONE;
		end
	endfunction : reg_sel

	// Last count of the interval a state times
	function automatic logic [23:0] interval_last(input seq_t s);
		case (s)
			SEQ_ACT1, SEQ_DEA1: interval_last = 24'(T1_CYCLES - 1);
			SEQ_ACT2, SEQ_DEA2: interval_last = 24'(T2_CYCLES - 1);
			SEQ_ACT3, SEQ_DEA3: interval_last = 24'(T3_CYCLES - 1);
			default: interval_last = 24'(T4_CYCLES - 1);
		endcase
	endfunction : interval_last

	////////////////////////////////////////////////////////////////////////////
	// Pin bundle and steering link
	assign pins = {i_overtemp, i_overcurrent, i_vdd_ok, i_vcc_ok, i_card_present, i_card_clk_src,
		i_card_aux_line_b, i_card_aux_line_a, i_card_data_line,
		i_host_side_aux_b, i_host_side_aux_a, i_host_side_data_line};
	assign st.en = q.ctrl[CTRL_IOEN_BIT] && q.recv;
	assign st.host_in = q.sync2[PIN_HOST +: 3];
	assign st.card_in = q.sync2[PIN_CARD +: 3];

	io_dir_steer u_steer (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.bus(st.steer)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next state of the whole block
	always_comb begin
		d = q;
		evt = '0;
		// Two-stage synchroniser, edge detectors read the second stage only
		d.sync1 = pins;
		d.sync2 = q.sync1;
		d.clk_prev = q.sync2[PIN_CLK];
		d.pres_prev = q.sync2[PIN_PRES];
		d.data_prev = q.sync2[PIN_CARD];
		card_edge = q.sync2[PIN_CLK] && !q.clk_prev;
		data_fall = q.data_prev && !q.sync2[PIN_CARD];
		d.start_prev = q.ctrl[CTRL_START_BIT];
		d.warm_prev = q.ctrl[CTRL_WARM_BIT];
		start_rise = q.ctrl[CTRL_START_BIT] && !q.start_prev;
		start_fall = !q.ctrl[CTRL_START_BIT] && q.start_prev;
		fault = q.sync2[PIN_OC] || q.sync2[PIN_OT] || !q.sync2[PIN_VDDOK] || !q.sync2[PIN_PRES];

		// Digital supply must stay valid for one first interval
		if (!q.sync2[PIN_VDDOK]) begin
			d.vdd_cnt = '0;
			d.vdd_stable = 1'b0;
		end else if (q.vdd_cnt == 24'(T1_CYCLES - 1)) begin
			d.vdd_stable = 1'b1;
		end else begin
			d.vdd_cnt = q.vdd_cnt + 24'h000001;
		end

		// AHB-Lite address phase, zero wait states
		acc = i_hsel && i_htrans[1] && i_hready;
		rd_status = acc && !i_hwrite && (reg_sel(i_haddr) == SEL_STATUS);
		d.ph_write = acc && i_hwrite;
		d.ph_sel = reg_sel(i_haddr);
		d.hready = 1'b1;
		if (acc && !i_hwrite) begin
			case (reg_sel(i_haddr))
				SEL_CTRL: d.hrdata = {24'h000000, q.ctrl};
				SEL_STATUS: d.hrdata = {24'h000000, q.status};
				default: d.hrdata = 32'h00000000;
			endcase
		end

		// Activation and deactivation sequencer
		d.cnt = q.cnt + 24'h000001;
		case (q.state)
			SEQ_OFF: begin
				d.cnt = '0;
				if (start_rise && q.vdd_stable) begin
					d.state = SEQ_ACT1;
					d.vcc_en = 1'b1;
				end
			end
			SEQ_ACT1: begin
				if (start_fall || fault) begin
					d.state = SEQ_DEA1;
					d.cnt = '0;
				end else if (q.cnt == interval_last(q.state)) begin
					d.cnt = '0;
					if (!q.sync2[PIN_VCCOK]) begin
						d.state = SEQ_DEA1;
						evt[STAT_VCCF_BIT] = 1'b1;
					end else begin
						d.state = SEQ_ACT2;
						d.recv = 1'b1;
					end
				end
			end
			SEQ_ACT2, SEQ_ACT3, SEQ_ON: begin
				if (start_fall || fault || !q.sync2[PIN_VCCOK]) begin
					d.state = SEQ_DEA1;
					d.cnt = '0;
					d.warm_active = 1'b0;
					d.atr_wait = 1'b0;
					evt[STAT_VCCF_BIT] = !q.sync2[PIN_VCCOK];
				end else if (q.state == SEQ_ON) begin
					d.cnt = '0;
				end else if (q.cnt == interval_last(q.state)) begin
					d.cnt = '0;
					if (q.state == SEQ_ACT2) begin
						d.state = SEQ_ACT3;
						d.clk_en = 1'b1;
					end else begin
						d.state = SEQ_ON;
						d.rst = 1'b1;
						d.atr_wait = 1'b1;
						d.atr_cnt = '0;
					end
				end
			end
			SEQ_DEA1, SEQ_DEA2, SEQ_DEA3, SEQ_DEA4: begin
				if (q.cnt == interval_last(q.state)) begin
					d.cnt = '0;
					case (q.state)
						SEQ_DEA1: begin
							d.state = SEQ_DEA2;
							d.rst = 1'b0;
						end
						SEQ_DEA2: begin
							d.state = SEQ_DEA3;
							d.clk_en = 1'b0;
						end
						SEQ_DEA3: begin
							d.state = SEQ_DEA4;
							d.recv = 1'b0;
						end
						default: begin
							d.state = SEQ_OFF;
							d.vcc_en = 1'b0;
						end
					endcase
				end
			end
			default: begin
				d.state = SEQ_OFF;
			end
		endcase

		// Warm reset pulse and answer watch, timed in card clock edges
		if (q.state == SEQ_ON && d.state == SEQ_ON) begin
			if (q.ctrl[CTRL_WARM_BIT] && !q.warm_prev) begin
				d.warm_active = 1'b1;
				d.atr_wait = 1'b0;
				d.atr_cnt = '0;
				d.rst = 1'b0;
			end else if (q.warm_active) begin
				if (card_edge && q.atr_cnt == 24'(WARM_CYCLES - 1)) begin
					d.warm_active = 1'b0;
					d.rst = 1'b1;
					d.atr_wait = 1'b1;
					d.atr_cnt = '0;
				end else if (card_edge) begin
					d.atr_cnt = q.atr_cnt + 24'h000001;
				end
			end else if (q.atr_wait) begin
				if (data_fall) begin
					d.atr_wait = 1'b0;
					d.ctrl[CTRL_WARM_BIT] = 1'b0;
				end else if (card_edge && q.atr_cnt == 24'(MUTE_CYCLES - 1)) begin
					d.atr_wait = 1'b0;
					d.ctrl[CTRL_WARM_BIT] = 1'b0;
					evt[STAT_MUTE_BIT] = 1'b1;
				end else if (card_edge) begin
					d.atr_cnt = q.atr_cnt + 24'h000001;
				end
			end
		end
		if (data_fall && q.recv && !q.rst && (q.state == SEQ_ACT3 || q.warm_active)) begin
			evt[STAT_EARLY_BIT] = 1'b1;
		end

		// Status events; a new event wins over the clear by a status read
		evt[STAT_OVERCUR_BIT] = q.sync2[PIN_OC];
		evt[STAT_OVERTEMP_BIT] = q.sync2[PIN_OT];
		// Gated by supply stable, so the synchroniser filling after reset is no false insertion
		evt[STAT_PRESCHG_BIT] = q.vdd_stable && (q.sync2[PIN_PRES] ^ q.pres_prev);
		d.status = (q.status & ~(rd_status ? STAT_EVT_MASK : 8'h00)) | (evt & STAT_EVT_MASK);
		d.status[STAT_PRESENT_BIT] = q.sync2[PIN_PRES];

		// Control write in the data phase; only defined bits are kept
		if (q.ph_write && q.ph_sel == SEL_CTRL) begin
			d.ctrl = i_hwdata[7:0] & CTRL_WMASK;
		end

		// Registered pin outputs
		d.vsel = q.ctrl[CTRL_VSEL_BIT];
		d.card_clk = q.sync2[PIN_CLK] && q.clk_en;
		d.int_n = q.vdd_stable && ((q.status & STAT_EVT_MASK) == 8'h00);
		d.card_oe = q.recv ? st.card_pull : 3'h7;
		d.host_oe = st.host_pull;
		d.line_val = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// State register; reset restores every register default
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			q <= '0;
			q.ctrl <= CTRL_RESET;
			q.status <= STATUS_RESET;
			q.state <= SEQ_OFF;
			q.hready <= 1'b1;
			q.card_oe <= 3'h7;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs, each straight from the state register
	assign o_hrdata = q.hrdata;
	assign o_hreadyout = q.hready;
	assign o_hresp = q.line_val;
	assign o_int_n = q.int_n;
	assign o_vcc_en = q.vcc_en;
	assign o_vcc_5v_sel = q.vsel;
	assign o_card_clk = q.card_clk;
	assign o_card_rst = q.rst;
	assign o_card_data_line = q.line_val;
	assign o_card_aux_line_a = q.line_val;
	assign o_card_aux_line_b = q.line_val;
	assign o_card_data_line_oe = q.card_oe[0];
	assign o_card_aux_line_a_oe = q.card_oe[1];
	assign o_card_aux_line_b_oe = q.card_oe[2];
	assign o_host_side_data_line = q.line_val;
	assign o_host_side_aux_a = q.line_val;
	assign o_host_side_aux_b = q.line_val;
	assign o_host_side_data_line_oe = q.host_oe[0];
	assign o_host_side_aux_a_oe = q.host_oe[1];
	assign o_host_side_aux_b_oe = q.host_oe[2];

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);

	vdd_holds_int_a: assert property (!q.vdd_stable |=> !o_int_n)
		else $error("interrupt released before supply stable");
	start_begins_a: assert property (q.state == SEQ_OFF && start_rise && q.vdd_stable |=> q.state == SEQ_ACT1)
		else $error("start edge did not activate");
	start_ignored_a: assert property (q.state == SEQ_OFF && !q.vdd_stable |=> q.state == SEQ_OFF)
		else $error("start acted before supply stable");
	vcc_abort_a: assert property (q.state == SEQ_ACT1 && q.cnt == 24'(T1_CYCLES - 1) && !fault && !start_fall
		&& !q.sync2[PIN_VCCOK] |=> q.state == SEQ_DEA1 && !q.recv)
		else $error("invalid card supply not aborted");
	act_order_a: assert property ($rose(q.rst) && !$past(q.warm_active) |-> q.clk_en && q.recv && q.vcc_en)
		else $error("activation order broken");
	fault_deact_a: assert property ((q.state == SEQ_ON) && (fault || start_fall) |=> q.state == SEQ_DEA1)
		else $error("fault did not deactivate");
	deact_order_a: assert property ($fell(o_vcc_en) |-> !o_card_rst && !q.clk_en && !q.recv)
		else $error("deactivation order broken");
	event_int_a: assert property ((q.status & STAT_EVT_MASK) != 8'h00 |=> !o_int_n)
		else $error("status event without interrupt");
	read_clears_a: assert property (rd_status && evt == 8'h00 |=> (q.status & STAT_EVT_MASK) == 8'h00)
		else $error("status read did not clear events");
	reset_default_a: assert property ($past(i_sys_rst) |-> q.ctrl == CTRL_RESET && q.state == SEQ_OFF)
		else $error("register not at default after reset");
	warm_clear_a: assert property (q.state == SEQ_ON && q.atr_wait && !q.warm_active && data_fall
		&& !start_fall && !fault && q.sync2[PIN_VCCOK] && !q.ph_write |=> !q.ctrl[CTRL_WARM_BIT])
		else $error("warm bit not cleared on answer");

	full_session_c: cover property (q.state == SEQ_ON ##[1:1000] q.state == SEQ_OFF);
	warm_pulse_c: cover property ($rose(q.warm_active));
	abort_c: cover property (q.state == SEQ_ACT1 ##1 q.state == SEQ_DEA1);

endmodule : sc_session_seq

/* verif/card_model.sv */
// Behavioural smart card on the card data contact.
// Assumes an open-drain data line with a pull-up, sampled on the system clock.
module card_model (
	// Clock and card contacts
	input wire logic i_clk_sys,
	input wire logic i_card_rst,
	input wire logic i_data_oe,
	input wire logic i_mute,
	output logic o_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic rst_q = 1'b0;
	logic pull = 1'b0;
	int cnt = 0;

	// Answer each rising card reset with a short low pulse, unless told to stay mute
	always @(posedge i_clk_sys) begin
		rst_q <= i_card_rst;
		if (i_card_rst && !rst_q) begin
			cnt <= 12;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
		pull <= !i_mute && (cnt > 1 && cnt < 5);
	end

	// Wired line: low if either side pulls, else the pull-up wins
	assign o_data = ~(i_data_oe | pull);
endmodule : card_model

/* verif/tb_smart_card_session_sequencer.sv */
// Self-checking bench of the smart card session sequencer.
// Assumes short interval parameters and bench pull-ups on all six lines.
module tb_smart_card_session_sequencer
	import sc_seq_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int TC = 8;
	localparam int WC = 20;
	localparam int MV = 0, MO = 1, MR = 2, MI = 3;
	logic clk = 0, rst = 1, hsel = 1, hwrite = 0, ot = 0, vcc_ok = 1, vdd_ok = 1, csrc = 0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic hreadyout, int_n, vcc_en, cclk, crst, cd, cd_oe, ca_oe, cb_oe, hd_oe, ha_oe, hb_oe;
	logic pres = 1, oc = 0, hd_drv = 1, mute = 0, hresp, vsel;
	int bad_count = 0, compares = 0, waited = 0, ccnt = 0, rcnt = 0;
	wire logic [3:0] mon = {int_n, crst, cd_oe, vcc_en};

	////////////////////////////////////////////////////////////////////////////
	// Clocks and counters of card clock and reset edges
	always #2 clk = ~clk;
	always #24 csrc = ~csrc;
	always @(posedge cclk) ccnt++;
	always @(posedge crst) rcnt++;

	sc_session_seq #(.T1_CYCLES(TC), .T2_CYCLES(TC), .T3_CYCLES(TC), .T4_CYCLES(TC),
		.WARM_CYCLES(WC), .MUTE_CYCLES(25)) u_sc_session_seq (
		.i_clk_sys(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout),
		.o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp), .o_int_n(int_n),
		.i_card_present(pres), .i_vcc_ok(vcc_ok), .i_vdd_ok(vdd_ok), .i_overcurrent(oc),
		.i_overtemp(ot), .i_card_clk_src(csrc), .o_vcc_en(vcc_en), .o_vcc_5v_sel(vsel),
		.o_card_clk(cclk), .o_card_rst(crst), .i_card_data_line(cd), .o_card_data_line(),
		.o_card_data_line_oe(cd_oe), .i_card_aux_line_a(~ca_oe), .o_card_aux_line_a(),
		.o_card_aux_line_a_oe(ca_oe), .i_card_aux_line_b(~cb_oe), .o_card_aux_line_b(),
		.o_card_aux_line_b_oe(cb_oe), .i_host_side_data_line(~hd_oe & hd_drv), .o_host_side_data_line(),
		.o_host_side_data_line_oe(hd_oe), .i_host_side_aux_a(~ha_oe), .o_host_side_aux_a(),
		.o_host_side_aux_a_oe(ha_oe), .i_host_side_aux_b(~hb_oe), .o_host_side_aux_b(),
		.o_host_side_aux_b_oe(hb_oe));

	card_model u_card_model (.i_clk_sys(clk), .i_card_rst(crst), .i_data_oe(cd_oe), .i_mute(mute), .o_data(cd));

	////////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic close_out();
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out

	// Compare one value against its expectation
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Bounded wait for one monitored output to reach a level
	task automatic wt(input int i, input logic v);
		waited = 0;
		while (mon[i] !== v && waited < 400) begin
			@(posedge clk);
			waited++;
		end
		if (waited == 400) begin
			bad_count++;
			close_out();
		end
	endtask : wt

	// One AHB-Lite single word transfer
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
		r = hrdata;
		if (n >= 100) begin
			bad_count++;
			close_out();
		end
	endtask : bus

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		logic [31:0] r;
		chk(int_n, 1'b0);
		chk({ca_oe, cb_oe, cd_oe}, 3'h7);
		chk({ha_oe, hb_oe, hd_oe}, 3'h0);
		bus(1'b0, 32'h0, 32'h0, r);
		chk(r, 32'h0);
		bus(1'b0, 32'h8, 32'h0, r);
		chk(r, 32'h0);
		bus(1'b0, 32'h4, 32'h0, r);
		chk(r, 32'h1);
		chk(hresp, 1'b0);
		wt(MI, 1'b1);
		bus(1'b0, 32'h4, 32'h0, r);
		chk(r, 32'h1);
		$display("reset test done");
	endtask : t_reset

	task automatic t_act();
		logic [31:0] r;
		int c;
		bus(1'b1, 32'h0, 32'h1, r);
		wt(MV, 1'b1);
		c = ccnt;
		wt(MO, 1'b0);
		chk({ccnt == c, crst}, 2'h2);
		wt(MR, 1'b1);
		repeat (13) @(posedge clk);
		chk(ccnt != c, 1'b1);
		$display("activation test done");
	endtask : t_act

	task automatic t_deact();
		logic [31:0] r;
		int c;
		bus(1'b1, 32'h0, 32'h0, r);
		wt(MR, 1'b0);
		chk({vcc_en, cd_oe}, 2'h2);
		wt(MO, 1'b1);
		c = ccnt;
		repeat (3) @(posedge clk);
		chk({ccnt == c, cclk, vcc_en}, 3'h5);
		wt(MV, 1'b0);
		$display("deactivation test done");
	endtask : t_deact

	task automatic t_ot();
		logic [31:0] r;
		t_act();
		ot <= 1'b1;
		wt(MI, 1'b0);
		wt(MV, 1'b0);
		ot <= 1'b0;
		repeat (6) @(posedge clk);
		bus(1'b0, 32'h4, 32'h0, r);
		chk(r[STAT_OVERTEMP_BIT], 1'b1);
		wt(MI, 1'b1);
		bus(1'b1, 32'h0, 32'h0, r);
		$display("over-temperature test done");
	endtask : t_ot

	task automatic t_abort();
		logic [31:0] r;
		int c;
		c = rcnt;
		vcc_ok <= 1'b0;
		bus(1'b1, 32'h0, 32'h1, r);
		wt(MV, 1'b1);
		wt(MI, 1'b0);
		wt(MV, 1'b0);
		chk(rcnt == c, 1'b1);
		vcc_ok <= 1'b1;
		bus(1'b1, 32'h0, 32'h0, r);
		repeat (6) @(posedge clk);
		bus(1'b0, 32'h4, 32'h0, r);
		chk(r[STAT_VCCF_BIT], 1'b1);
		wt(MI, 1'b1);
		$display("abort test done");
	endtask : t_abort

	task automatic t_vdd();
		logic [31:0] r;
		t_act();
		vdd_ok <= 1'b0;
		wt(MI, 1'b0);
		wt(MV, 1'b0);
		bus(1'b0, 32'h0, 32'h0, r);
		chk(r, 32'h1);
		vdd_ok <= 1'b1;
		wt(MI, 1'b1);
		chk(waited >= TC, 1'b1);
		bus(1'b1, 32'h0, 32'h0, r);
		$display("supply fault test done");
	endtask : t_vdd

	task automatic t_warm();
		logic [31:0] r;
		int c;
		t_act();
		repeat (8) @(posedge clk);
		bus(1'b1, 32'h0, 32'h3, r);
		wt(MR, 1'b0);
		c = ccnt;
		wt(MR, 1'b1);
		chk(ccnt - c, WC);
		repeat (20) @(posedge clk);
		bus(1'b0, 32'h0, 32'h0, r);
		chk(r, 32'h1);
		mute <= 1'b1;
		bus(1'b1, 32'h0, 32'h3, r);
		wt(MR, 1'b0);
		wt(MR, 1'b1);
		wt(MI, 1'b0);
		bus(1'b0, 32'h4, 32'h0, r);
		chk(r, 32'h5);
		bus(1'b0, 32'h0, 32'h0, r);
		chk(r, 32'h1);
		mute <= 1'b0;
		bus(1'b1, 32'h0, 32'h0, r);
		wt(MV, 1'b0);
		$display("warm reset test done");
	endtask : t_warm

	task automatic t_steer();
		logic [31:0] r;
		t_act();
		bus(1'b1, 32'h0, 32'h85, r);
		hd_drv <= 1'b0;
		wt(MO, 1'b1);
		chk({hd_oe, vsel}, 2'h1);
		hd_drv <= 1'b1;
		wt(MO, 1'b0);
		bus(1'b1, 32'h0, 32'h0, r);
		wt(MV, 1'b0);
		chk(vsel, 1'b0);
		$display("steering test done");
	endtask : t_steer

	task automatic t_pres();
		logic [31:0] r;
		t_act();
		pres <= 1'b0;
		wt(MV, 1'b0);
		bus(1'b0, 32'h4, 32'h0, r);
		chk(r, 32'h40);
		pres <= 1'b1;
		oc <= 1'b1;
		repeat (6) @(posedge clk);
		oc <= 1'b0;
		repeat (6) @(posedge clk);
		bus(1'b0, 32'h4, 32'h0, r);
		chk(r, 32'h49);
		wt(MI, 1'b1);
		bus(1'b1, 32'h0, 32'h0, r);
		$display("card removal test done");
	endtask : t_pres

	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_act();
		t_deact();
		t_warm();
		t_steer();
		t_pres();
		t_ot();
		t_abort();
		t_vdd();
		close_out();
	end
endmodule : tb_smart_card_session_sequencer
